// [dv/cicr_far_model.sv]
// Purpose: Far-side model that answers the bank's start, detection and kick flags
// Assumes: Each flag is a level that stays up until its answer pulse lands
// Notes:   slow_i stretches every answer, so late completions are tested
`timescale 1ns/1ps
`default_nettype none
module cicr_far_model (
  // Clock and pace
  input  wire logic clk_i,
  input  wire logic slow_i,
  // Flags from the bank
  input  wire logic force_opt_i,
  input  wire logic force_det_i,
  input  wire logic kick_i,
  // One-cycle answer pulses
  output logic      started_o,
  output logic      det_done_o,
  output logic      cleared_o
);
  // Optimizer reports that it began, after a prompt or a slow delay
  // One process per answer keeps each output on a single driver
  initial begin
    started_o = 1'b0;
    forever begin
      @(posedge clk_i iff force_opt_i);
      repeat (slow_i ? 20 : 3) @(posedge clk_i);
      #1 started_o = 1'b1;
      @(posedge clk_i);
      #1 started_o = 1'b0;
    end
  end
  // Adapter detection finishes and drops the force flag
  initial begin
    det_done_o = 1'b0;
    forever begin
      @(posedge clk_i iff force_det_i);
      repeat (slow_i ? 20 : 3) @(posedge clk_i);
      #1 det_done_o = 1'b1;
      @(posedge clk_i);
      #1 det_done_o = 1'b0;
    end
  end
  // Watchdog timer restart is confirmed so the kick bit can clear
  initial begin
    cleared_o = 1'b0;
    forever begin
      @(posedge clk_i iff kick_i);
      repeat (slow_i ? 20 : 3) @(posedge clk_i);
      #1 cleared_o = 1'b1;
      @(posedge clk_i);
      #1 cleared_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dv/test_charger_input_timer_config_regs.sv]
// Purpose: Self-checking bench for the charger configuration registers
// Assumes: One-cycle byte strobes, inputs driven 1 ns after the edge
// Notes:   Random register contents and limits come from a fixed LFSR
`timescale 1ns/1ps
`default_nettype none
module test_charger_input_timer_config_regs;
  import cicr_pkg::*;
  logic         clk_i, nrst_i, ce_i, soft_reset_i, wr_i, rd_i, slow;
  logic [7:0]   addr_i, wdata_i, rdata_o, r3, r4, r5;
  logic         started, det_done, kick_set, wd_cleared, input_power_management, thermal_regulation;
  logic         fos, fpd, oen, kick;
  logic [15:0]  oi, pin, det;
  logic [31:0]  rnd;
  cicr_cfg_type cfg_o;
  int           num_errors, num_checks;

  cicr_regs i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .soft_reset_i(soft_reset_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .optimizer_started_i(started), .detection_done_i(det_done),
    .optimizer_current_result_i(oi), .current_limit_pin_i(pin),
    .detection_limit_i(det), .input_power_management_i(input_power_management),
    .thermal_regulation_i(thermal_regulation), .watchdog_kick_set_i(kick_set),
    .watchdog_cleared_i(wd_cleared), .watchdog_kick_o(kick),
    .force_optimizer_start_o(fos), .force_port_detection_o(fpd),
    .optimizer_enable_o(oen), .cfg_o(cfg_o));
  cicr_far_model i_far (.clk_i(clk_i), .slow_i(slow), .force_opt_i(fos),
    .force_det_i(fpd), .kick_i(kick), .started_o(started),
    .det_done_o(det_done), .cleared_o(wd_cleared));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Decoded configuration expected from three register bytes
  function automatic cicr_cfg_type exp_cfg(input logic [7:0] a, b, c);
    cicr_cfg_type e;
    logic [15:0]  m;
    m = (a[4:0] > 5'h1c) ? 16'h0ce4 : 16'h01f4 + 16'h0064 * a[4:0];
    if (oi < m) m = oi;
    if (pin < m) m = pin;
    if (det < m) m = det;
    e.input_limit_ma = m;
    e.precharge_ma = 12'h032 + 12'h032 * b[7:4];
    e.termination_ma = 12'h032 + 12'h032 * b[3:0];
    e.term_enable = c[7];
    e.status_pin_disable = c[6];
    e.watchdog_sec = (c[5:4] == 2'h0) ? 8'h00 : 8'h14 << c[5:4];
    e.safety_timer_enable = c[3];
    e.fast_charge_hours = (c[2:1] == 2'h0) ? 5'h05 : (c[2:1] == 2'h1) ?
      5'h08 : (c[2:1] == 2'h2) ? 5'h0c : 5'h14;
    e.slow_timer_half_rate = c[0] & (input_power_management | thermal_regulation);
    return e;
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 {wr_i, addr_i, wdata_i} = {1'b1, a, d};
    @(posedge clk_i);
    #1 wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #1 {rd_i, addr_i} = {1'b1, a};
    @(posedge clk_i);
    #1 rd_i = 1'b0;
    @(posedge clk_i);
    #1 chk(64'(rdata_o), 64'(e));
  endtask

  // Bounded wait until every pending flag has been answered
  task automatic wait_idle;
    int n;
    n = 0;
    while ((fos | fpd | kick) !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if ((fos | fpd | kick) !== 1'b0) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic reset_check;
    {r3, r4, r5} = {8'h39, 8'h22, 8'h9d};
    rd(8'h03, r3);
    rd(8'h04, r4);
    rd(8'h05, r5);
    chk(64'(cfg_o), 64'(exp_cfg(r3, r4, r5)));
    chk(64'(oen), 64'h1);
  endtask

  initial begin
    {nrst_i, soft_reset_i, wr_i, rd_i, kick_set, input_power_management, thermal_regulation, slow} = '0;
    {ce_i, addr_i, wdata_i, oi, pin, det} = {1'b1, 16'h0, {3{16'hffff}}};
    {rnd, num_errors, num_checks} = {32'h11af_2467, 64'h0};
    repeat (4) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    reset_check();
    // Random bytes and limits, every input current code once
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      {r3, r4, r5} = {2'h0, rnd[20], i[4:0], rnd[15:0]};
      wr(8'h03, r3);
      wr(8'h04, r4);
      wr(8'h05, r5);
      {oi, pin, det} = {3{16'hffff}};
      case (rnd[17:16])
        2'h0: oi = {4'h0, rnd[31:20]};
        2'h1: pin = {4'h0, rnd[31:20]};
        2'h2: det = {4'h0, rnd[31:20]};
        default: ;
      endcase
      {input_power_management, thermal_regulation} = rnd[19:18];
      rd(8'h03, r3);
      rd(8'h04, r4);
      rd(8'h05, r5);
      chk(64'(oen), 64'(r3[5]));
      chk(64'(cfg_o), 64'(exp_cfg(r3, r4, r5)));
    end
    // Force start refused while the optimizer is off
    wr(8'h03, 8'h99);
    chk(64'(fos), 64'h0);
    rd(8'h03, 8'h19);
    // Force start with enable in the same byte, slow far side
    slow = 1'b1;
    wr(8'h03, 8'hb9);
    chk(64'(fos), 64'h1);
    // Pending start reads as one and a host write of zero cannot drop it
    rd(8'h03, 8'hb9);
    wr(8'h03, 8'h39);
    chk(64'(fos), 64'h1);
    wait_idle();
    rd(8'h03, 8'h39);
    slow = 1'b0;
    wr(8'h03, 8'h79);
    chk(64'(fpd), 64'h1);
    wait_idle();
    rd(8'h03, 8'h39);
    // Watchdog kick is held until the restart is confirmed
    @(posedge clk_i);
    #1 kick_set = 1'b1;
    @(posedge clk_i);
    #1 kick_set = 1'b0;
    chk(64'(kick), 64'h1);
    wait_idle();
    chk(64'(kick), 64'h0);
    // Unmapped byte is dropped and reads zero
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    // Register reset restores every default, from non-default contents
    wr(8'h03, 8'h05);
    {oi, pin, det, input_power_management, thermal_regulation} = {{3{16'hffff}}, 2'h0};
    @(posedge clk_i);
    #1 soft_reset_i = 1'b1;
    @(posedge clk_i);
    #1 soft_reset_i = 1'b0;
    reset_check();
    // Clock enable low freezes the bank, so this write is lost
    ce_i = 1'b0;
    wr(8'h05, 8'h00);
    ce_i = 1'b1;
    rd(8'h05, 8'h9d);
    close_out();
  end
endmodule
`default_nettype wire

// [hdl/cicr_regs.sv]
// Purpose: Input current, precharge/termination and control-one registers
// Assumes: Byte reads and writes from the serial front end, one cycle each
// Notes:   Force bits self-clear once the analog side reports start or detection done
//
// Behaviour
// - Input current register at 03h, reset 39h
// - Force-optimizer write starts optimizer, reads zero after
// - Force-optimizer honoured only while optimizer enabled
// - Force-detection write starts adapter detection
// - Bit 5 enables optimization algorithm
// - Limit code: 500 mA plus 100 mA per step
// - Codes above 1Ch clamp to 3300 mA
// - Applied limit is minimum of four limits
// - Control register 05h resets 9Dh, bit7 termination
// - Bit 6 disables status pin
// - Watchdog field selects off, 40, 80, 160 s
// - Bit 3 enables safety timer
// - Fast-charge field selects 5, 8, 12, 20 h
// - Bit 0 halves timer rate during regulation
// - Watchdog kick bit clears after timer reset
`include "cicr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cicr_regs (
  // Clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  ce_i,
  input  wire logic                  soft_reset_i,
  // Byte register access
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  output logic      [7:0]            rdata_o,
  // Analog side status
  input  wire logic                  optimizer_started_i,
  input  wire logic                  detection_done_i,
  input  wire logic [15:0]           optimizer_current_result_i,
  input  wire logic [15:0]           current_limit_pin_i,
  input  wire logic [15:0]           detection_limit_i,
  input  wire logic                  input_power_management_i,
  input  wire logic                  thermal_regulation_i,
  // Watchdog kick handshake
  input  wire logic                  watchdog_kick_set_i,
  input  wire logic                  watchdog_cleared_i,
  output logic                       watchdog_kick_o,
  // Outputs to the charge loops
  output logic                       force_optimizer_start_o,
  output logic                       force_port_detection_o,
  output logic                       optimizer_enable_o,
  output cicr_pkg::cicr_cfg_type     cfg_o
);
  import cicr_pkg::*;

  // Stored registers
  logic [7:0]   icl_reg, icl_next;      // Input current limit control
  logic [7:0]   ptc_reg, ptc_next;      // Precharge and termination
  logic [7:0]   cc1_reg, cc1_next;      // Charger control one
  logic         kick_reg, kick_next;    // Watchdog kick flag
  logic [7:0]   rdata_reg;              // Read data holding
  cicr_cfg_type cfg_reg;                // Registered decoded config
  cicr_opt_type opt_reg, opt_next;      // Optimizer start sequencing

  // Decode strobes
  wire wr_icl = wr_i && (addr_i == `CICR_ADDR_ICL);
  wire wr_ptc = wr_i && (addr_i == `CICR_ADDR_PTC);
  wire wr_cc1 = wr_i && (addr_i == `CICR_ADDR_CC1);

  // Five-bit code to milliamps, clamped at the top code
  function automatic logic [15:0] iin_ma(input logic [4:0] code);
    logic [4:0] c;
    c = (code > `CICR_CODE_MAX) ? `CICR_CODE_MAX : code;
    iin_ma = `CICR_IIN_BASE_MA + 16'({11'h000, c} * `CICR_IIN_STEP_MA);
  endfunction

  // Four-bit code to milliamps, shared by the precharge and termination fields
  function automatic logic [11:0] pt_ma(input logic [3:0] code);
    pt_ma = `CICR_PT_BASE_MA + 12'({8'h00, code} * `CICR_PT_STEP_MA);
  endfunction

  // Smaller of two limits
  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  // Optimizer start accepted only with enable held at one
  wire opt_en_now = wr_icl ? wdata_i[`CICR_BIT_OEN]
                           : icl_reg[`CICR_BIT_OEN];
  wire opt_req = wr_icl && wdata_i[`CICR_BIT_FOS] && opt_en_now;

  // Next state of optimizer sequencing
  always_comb begin
    opt_next = opt_reg;
    unique case (opt_reg)
      CICR_OPT_IDLE: begin
        if (opt_req) begin
          opt_next = CICR_OPT_START;
        end
      end
      CICR_OPT_START: begin
        // Started, or enable withdrawn: drop the request
        if (optimizer_started_i || !icl_reg[`CICR_BIT_OEN]) begin
          opt_next = CICR_OPT_IDLE;
        end
      end
    endcase
  end

  // Register next values; hardware clears lose to host writes of one
  always_comb begin
    icl_next = icl_reg;
    ptc_next = ptc_reg;
    cc1_next = cc1_reg;
    kick_next = kick_reg;
    if (detection_done_i) begin
      icl_next[`CICR_BIT_FPD] = 1'b0;
    end
    if (wr_icl) begin
      icl_next = {1'b0, wdata_i[`CICR_FLD_KEEP]};
    end
    if (wr_ptc) begin
      ptc_next = wdata_i;
    end
    if (wr_cc1) begin
      cc1_next = wdata_i;
    end
    if (watchdog_cleared_i) begin
      kick_next = 1'b0;
    end
    if (watchdog_kick_set_i) begin
      kick_next = 1'b1;
    end
    if (soft_reset_i) begin
      icl_next = `CICR_RST_ICL;
      ptc_next = `CICR_RST_PTC;
      cc1_next = `CICR_RST_CC1;
      kick_next = 1'b0;
    end
  end

  // Read mux; force-optimizer reads as pending request only
  wire [7:0] icl_rd = {opt_reg == CICR_OPT_START, icl_reg[`CICR_FLD_KEEP]};
  wire [7:0] rd_mux =
    (addr_i == `CICR_ADDR_ICL) ? icl_rd :
    (addr_i == `CICR_ADDR_PTC) ? ptc_reg :
    (addr_i == `CICR_ADDR_CC1) ? cc1_reg : 8'h00;

  // Watchdog timeout decode
  wire [1:0] wd_sel = cc1_reg[`CICR_FLD_WD];
  wire [7:0] wd_sec = (wd_sel == `CICR_WD_OFF)  ? `CICR_WD_OFF_SEC :
                      (wd_sel == `CICR_WD_40S)  ? `CICR_WD_40S_SEC :
                      (wd_sel == `CICR_WD_80S)  ? `CICR_WD_80S_SEC :
                                                  `CICR_WD_160S_SEC;
  // Fast charge time decode
  wire [1:0] fc_sel = cc1_reg[`CICR_FLD_FC];
  wire [4:0] fc_hrs = (fc_sel == `CICR_FC_5H)  ? `CICR_FC_5H_HRS :
                      (fc_sel == `CICR_FC_8H)  ? `CICR_FC_8H_HRS :
                      (fc_sel == `CICR_FC_12H) ? `CICR_FC_12H_HRS :
                                                 `CICR_FC_20H_HRS;
  // Applied limit: minimum of four sources
  wire [15:0] lim_all = min16(min16(iin_ma(icl_reg[`CICR_FLD_CODE]),
                                    optimizer_current_result_i),
                              min16(current_limit_pin_i,
                                    detection_limit_i));
  // Half-rate only while regulating and enabled
  wire half_rate = cc1_reg[`CICR_BIT_S2X] &&
                   (input_power_management_i || thermal_regulation_i);

  // Decoded configuration next value
  cicr_cfg_type cfg_next;
  assign cfg_next = '{input_limit_ma:       lim_all,
                      precharge_ma:         pt_ma(ptc_reg[`CICR_FLD_PRE]),
                      termination_ma:       pt_ma(ptc_reg[`CICR_FLD_TERM]),
                      term_enable:          cc1_reg[`CICR_BIT_TEN],
                      status_pin_disable:   cc1_reg[`CICR_BIT_SPD],
                      watchdog_sec:         wd_sec,
                      safety_timer_enable:  cc1_reg[`CICR_BIT_STE],
                      fast_charge_hours:    fc_hrs,
                      slow_timer_half_rate: half_rate};

  // State registers; clock enable freezes everything
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      icl_reg   <= `CICR_RST_ICL;
      ptc_reg   <= `CICR_RST_PTC;
      cc1_reg   <= `CICR_RST_CC1;
      kick_reg  <= 1'b0;
      opt_reg   <= CICR_OPT_IDLE;
      rdata_reg <= 8'h00;
      cfg_reg   <= '0;
    end else if (ce_i) begin
      icl_reg   <= icl_next;
      ptc_reg   <= ptc_next;
      cc1_reg   <= cc1_next;
      kick_reg  <= kick_next;
      opt_reg   <= soft_reset_i ? CICR_OPT_IDLE : opt_next;
      rdata_reg <= rd_i ? rd_mux : rdata_reg;
      cfg_reg   <= cfg_next;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o                 = rdata_reg;
  assign watchdog_kick_o         = kick_reg;
  assign force_optimizer_start_o = (opt_reg == CICR_OPT_START);
  assign force_port_detection_o  = icl_reg[`CICR_BIT_FPD];
  assign optimizer_enable_o      = icl_reg[`CICR_BIT_OEN];
  assign cfg_o                   = cfg_reg;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_opt_gated: assert property (
    ce_i && !soft_reset_i && wr_icl && wdata_i[`CICR_BIT_FOS]
    && !wdata_i[`CICR_BIT_OEN] && opt_reg == CICR_OPT_IDLE
    |=> !force_optimizer_start_o)
    else $error("optimizer forced while disabled");
  a_opt_start: assert property (
    ce_i && !soft_reset_i && opt_req && opt_reg == CICR_OPT_IDLE
    |=> force_optimizer_start_o)
    else $error("optimizer start not raised");
  a_opt_clear: assert property (
    ce_i && force_optimizer_start_o && optimizer_started_i
    |=> !force_optimizer_start_o)
    else $error("force bit stuck after start");
  a_kick_clear: assert property (
    ce_i && watchdog_cleared_i && !watchdog_kick_set_i |=> !watchdog_kick_o)
    else $error("kick not cleared");
  a_wr_cc1: assert property (
    ce_i && wr_cc1 && !soft_reset_i |=> ##1 (ce_i -> cfg_o.term_enable ==
                                         $past(wdata_i[`CICR_BIT_TEN], 2)))
    else $error("termination enable mismatch");
  a_lim_clamp: assert property (
    cfg_o.input_limit_ma <= `CICR_IIN_MAX_MA)
    else $error("input limit above maximum");
  a_lim_min: assert property (
    ce_i |=> !ce_i || cfg_o.input_limit_ma <= $past(current_limit_pin_i))
    else $error("limit exceeds pin limit");
  a_read_zero: assert property (
    ce_i && rd_i && addr_i == `CICR_ADDR_ICL && opt_reg == CICR_OPT_IDLE
    |=> !rdata_o[`CICR_BIT_FOS])
    else $error("force bit read as one");
  c_opt_run:  cover property (opt_req ##[1:20] optimizer_started_i);
  c_kick:     cover property (watchdog_kick_o ##[1:20] !watchdog_kick_o);
  c_half:     cover property (cfg_o.slow_timer_half_rate);
endmodule
`default_nettype wire

// [include/cicr_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: 8-bit register bank with byte addresses
// Notes:   Included by the register bank; the package does not use it
`ifndef CICR_CFG_SVH
`define CICR_CFG_SVH
`define CICR_ADDR_ICL      8'h03
`define CICR_ADDR_PTC      8'h04
`define CICR_ADDR_CC1      8'h05
`define CICR_RST_ICL       8'h39
`define CICR_RST_PTC       8'h22
`define CICR_RST_CC1       8'h9d
`define CICR_BIT_FOS       7
`define CICR_BIT_FPD       6
`define CICR_BIT_OEN       5
`define CICR_BIT_TEN       7
`define CICR_BIT_SPD       6
`define CICR_BIT_STE       3
`define CICR_BIT_S2X       0
`define CICR_CODE_MAX      5'h1c
`define CICR_IIN_MAX_MA    16'h0ce4
`define CICR_FLD_CODE      4:0
`define CICR_FLD_KEEP      6:0
`define CICR_FLD_PRE       7:4
`define CICR_FLD_TERM      3:0
`define CICR_FLD_WD        5:4
`define CICR_FLD_FC        2:1
`define CICR_WD_OFF_SEC    8'h00
`define CICR_IIN_BASE_MA   16'h01f4
`define CICR_IIN_STEP_MA   16'h0064
`define CICR_PT_BASE_MA    12'h032
`define CICR_PT_STEP_MA    12'h032
`define CICR_WD_OFF        2'h0
`define CICR_WD_40S        2'h1
`define CICR_WD_80S        2'h2
`define CICR_WD_160S       2'h3
`define CICR_WD_40S_SEC    8'h28
`define CICR_WD_80S_SEC    8'h50
`define CICR_WD_160S_SEC   8'ha0
`define CICR_FC_5H         2'h0
`define CICR_FC_8H         2'h1
`define CICR_FC_12H        2'h2
`define CICR_FC_20H        2'h3
`define CICR_FC_5H_HRS     5'h05
`define CICR_FC_8H_HRS     5'h08
`define CICR_FC_12H_HRS    5'h0c
`define CICR_FC_20H_HRS    5'h14
`endif

// [include/cicr_pkg.sv]
// Purpose: Types for the charger configuration register bank
// Assumes: cicr_cfg.svh holds the numbers
// Notes:   Decoded fields travel as one packed struct
package cicr_pkg;
  // Decoded configuration handed to the analog loops
  typedef struct packed {
    logic [15:0] input_limit_ma;        // Applied input current limit
    logic [11:0] precharge_ma;          // Precharge current
    logic [11:0] termination_ma;        // Termination current
    logic        term_enable;           // Charge termination enable
    logic        status_pin_disable;    // Status pin disabled
    logic [7:0]  watchdog_sec;          // Watchdog timeout, 0 = off
    logic        safety_timer_enable;   // Safety timer enable
    logic [4:0]  fast_charge_hours;     // Fast charge time limit
    logic        slow_timer_half_rate;  // Safety timer at half rate now
  } cicr_cfg_type;
  // Optimizer sequencing states
  typedef enum logic [1:0] {
    CICR_OPT_IDLE  = 2'b01,
    CICR_OPT_START = 2'b10
  } cicr_opt_type;
endpackage
